// *** dv/exposure_start_trigger_control_properties.sv ***
/* Port checker for the exposure start controller.
   Assumes a bind onto the top module and a single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module exposure_start_props (
  input wire logic        clock_i,                // Clock
  input wire logic        nrst_i,                 // Reset, active low
  input wire logic        psel_i,                 // APB select
  input wire logic        penable_i,              // APB enable
  input wire logic        pwrite_i,               // APB write
  input wire logic [11:0] paddr_i,                // APB address
  input wire logic [31:0] pwdata_i,               // APB write data
  input wire logic        pready_o,               // APB ready
  input wire logic [31:0] prdata_o,               // APB read data
  input wire logic        pslverr_o,              // APB error
  input wire logic [3:0]  external_start_input_i, // Trigger pins
  input wire logic        start_ready_flag_o,     // Start ready
  input wire logic        exposing_o,             // Exposure
  input wire logic        readout_start_o         // Readout pulse
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================================================
  // Shadow of the control registers
  logic [31:0] mode_q;
  logic        rep_q;
  logic [11:0] shut_q;
  logic [23:0] cnt;
  wire         wr  = psel_i && penable_i && pwrite_i;
  wire         pin = external_start_input_i[mode_q[22:21]];
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q <= 32'h0100_0000;
      rep_q  <= 1'b0;
      shut_q <= 12'h064;
      cnt    <= 24'h000000;
    end else begin
      cnt <= exposing_o ? cnt + 24'h000001 : 24'h000000;
      if (wr && paddr_i == 12'h000) mode_q <= pwdata_i;
      if (wr && paddr_i == 12'h00C) rep_q <= pwdata_i[0];
      // A zero shutter write is refused
      if (wr && paddr_i == 12'h008 && pwdata_i[11:0] != 12'h000) shut_q <= pwdata_i[11:0];
    end
  end
  // ==========================================================================
  // Properties
  chk_ready_low: assert property (exposing_o |-> !start_ready_flag_o)
    else $error("start ready high during exposure");
  chk_readout_end: assert property ($fell(exposing_o) |-> readout_start_o)
    else $error("no readout pulse at exposure end");
  chk_readout_pulse: assert property (readout_start_o |-> !exposing_o ##1 !readout_start_o)
    else $error("readout pulse malformed");
  chk_soft_start: assert property (wr && paddr_i == 12'h004 && pwdata_i[0] && mode_q[25] && rep_q
    && mode_q[23:21] == 3'h7 && start_ready_flag_o |-> ##[1:2] exposing_o)
    else $error("soft fire did not start exposure");
  chk_prog_length: assert property ($fell(exposing_o) && (!mode_q[16] || mode_q[23:21] == 3'h7)
    |-> cnt >= shut_q * 1000 && cnt <= shut_q * 1000 + 1)
    else $error("programmable exposure length wrong");
  chk_min_length: assert property ($fell(exposing_o) |-> cnt >= shut_q * 1000)
    else $error("exposure shorter than shutter minimum");
  chk_pin_start: assert property (((mode_q[24] && $rose(pin)) || (!mode_q[24] && $fell(pin)))
    && mode_q[25] && rep_q && !mode_q[23] && start_ready_flag_o |-> ##[2:5] exposing_o)
    else $error("pin edge did not start exposure");
  chk_unmapped_err: assert property (psel_i && penable_i && paddr_i > 12'h00C |-> pslverr_o && pready_o)
    else $error("unmapped access without error");
endmodule
bind exposure_start_trigger_control exposure_start_props i_exposure_start_props (.*);
`default_nettype wire

// *** dv/exposure_start_trigger_control_tb.sv ***
/* Self-checking bench for the exposure start controller.
   Assumes the trigger source model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module exposure_start_trigger_control_tb;
  logic        clock_i, nrst_i, psel, penable, pwrite, go, act;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [1:0]  port, pt;
  logic [15:0] width;
  wire         pready_o, pslverr_o, start_ready_flag_o, exposing_o, readout_start_o;
  wire  [31:0] prdata_o;
  wire  [3:0]  pins;
  int          fails = 0, compares = 0, seed = 49571, cnt = 0, p;
  logic [32:0] rq[$];
  int          eq[$];
  logic [11:0] ra[5] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
  logic [32:0] rv[5] = '{33'h0_0100_0000, 33'h0, 33'h0_0000_0064, 33'h0, 33'h1_0000_0000};
  exposure_start_trigger_control i_exposure_start_trigger_control (.clock_i(clock_i), .nrst_i(nrst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .external_start_input_i(pins),
    .start_ready_flag_o(start_ready_flag_o), .exposing_o(exposing_o), .readout_start_o(readout_start_o));
  trigger_source_model i_trigger_source_model (.clock_i(clock_i), .ready_i(start_ready_flag_o),
    .port_i(port), .active_high_i(act), .go_i(go), .width_i(width), .pins_o(pins));
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // ==========================================================================
  // Drivers and compares
  function automatic logic [31:0] mv(input logic pol, input logic [2:0] src, input logic lvl);
    return {6'h00, 1'b1, pol, src, 4'h0, lvl, 16'h0000};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge clock_i);
    if (!w) rq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input logic [1:0] pp, input int w);
    port <= pp;
    width <= w[15:0];
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
  endtask
  task automatic drain;
    while (eq.size() != 0) @(posedge clock_i);
  endtask
  task automatic chk(input logic [32:0] e, input logic [32:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("mismatch apb read expected %h seen %h", e, s);
    end
  endtask
  task automatic chk_len(input int e, input int s);
    compares++;
    if (!(s >= e && s <= e + 3)) begin
      fails++;
      $display("mismatch exposure cycles expected %0d seen %0d", e, s);
    end
  endtask
  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock_i) begin
    if (psel && penable && pready_o === 1'b1 && !pwrite) chk(rq.pop_front(), {pslverr_o, prdata_o});
    if (exposing_o === 1'b1) cnt = cnt + 1;
    else if (cnt != 0) begin
      chk_len(eq.size() != 0 ? eq.pop_front() : -9, cnt);
      cnt = 0;
    end
  end
  initial begin
    #800000;
    fails++;
    conclude;
  end
  // ==========================================================================
  // Scenarios
  initial begin
    {nrst_i, psel, penable, pwrite, go, paddr, pwdata, port, width} = '0;
    act = 1'b1;
    repeat (5) @(posedge clock_i);
    nrst_i <= 1'b1;
    foreach (ra[i]) apb(1'b0, ra[i], 32'h0, rv[i]);
    apb(1'b1, 12'h008, 32'h0, 33'h0);
    apb(1'b0, 12'h008, 32'h0, 33'h0_0000_0064);
    $display("test reset values done");
    apb(1'b1, 12'h008, 32'h1, 33'h0);
    apb(1'b1, 12'h00C, 32'h1, 33'h0);
    apb(1'b1, 12'h000, mv(1'b0, 3'h7, 1'b1), 33'h0);
    repeat (2) begin
      eq.push_back(1000);
      apb(1'b1, 12'h004, 32'h1, 33'h0);
      apb(1'b0, 12'h004, 32'h0, 33'h0);
      drain;
    end
    $display("test software trigger done");
    for (int i = 0; i < 2; i++) begin
      pt = 2'($random(seed));
      apb(1'b1, 12'h000, mv(i[0], {1'b0, pt}, 1'b0), 33'h0);
      act <= i[0];
      eq.push_back(1000);
      pulse(pt, 60);
      drain;
    end
    $display("test pin edges done");
    apb(1'b1, 12'h008, 32'h2, 33'h0);
    apb(1'b1, 12'h000, mv(1'b1, {1'b0, pt}, 1'b1), 33'h0);
    eq.push_back(2000);
    pulse(pt, 60);
    drain;
    p = 2100 + ({$random(seed)} % 400);
    eq.push_back(p);
    pulse(pt, p);
    drain;
    $display("test level mode done");
    apb(1'b1, 12'h00C, 32'h0, 33'h0);
    pulse(pt, 60);
    repeat (3000) @(posedge clock_i);
    $display("test repeat off done");
    eq.push_back(2000);
    apb(1'b1, 12'h00C, 32'h2, 33'h0);
    drain;
    apb(1'b0, 12'h00C, 32'h0, 33'h0_0000_0004);
    $display("test single capture done");
    conclude;
  end
endmodule
`default_nettype wire

// *** dv/trigger_source_model.sv ***
/* External trigger source: one pulse on a chosen pin per request.
   Assumes the device's start ready flag and the bench clock. */
`timescale 1ns/1ps
`default_nettype none
module trigger_source_model (
  input  wire logic        clock_i,       // System clock
  input  wire logic        ready_i,       // Start ready from device
  input  wire logic [1:0]  port_i,        // Pin to pulse
  input  wire logic        active_high_i, // Active level
  input  wire logic        go_i,          // Request one pulse
  input  wire logic [15:0] width_i,       // Active cycles
  output logic      [3:0]  pins_o         // Trigger pins
);
  logic on = 1'b0;
  int   n;
  assign pins_o = {4{~active_high_i}} ^ (on ? 4'h1 << port_i : 4'h0);
  initial forever begin
    @(posedge clock_i);
    if (go_i === 1'b1) begin
      while (ready_i !== 1'b1) @(posedge clock_i);
      on <= 1'b1;
      n = (width_i < 16'h0032) ? 50 : width_i;
      repeat (n) @(posedge clock_i);
      on <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** verilog/exposure_start_defs.vh ***
/*
 * Constants for the exposure start controller: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 50 MHz system clock and a 32-bit APB register bus.
 */
`ifndef EXPOSURE_START_DEFS_VH
`define EXPOSURE_START_DEFS_VH

// ==========================================================================
// Register byte offsets
`define REG_TRIG_MODE      4'h0
`define REG_SOFT_FIRE      4'h4
`define REG_SHUTTER        4'h8
`define REG_CAPTURE        4'hC

// ==========================================================================
// Trigger mode fields
`define TM_ENABLE_BIT      25
`define TM_POLARITY_BIT    24
`define TM_MODE_BIT        16
`define TM_SOURCE_LSB      21
`define TM_SOURCE_MSB      23
`define SRC_SOFTWARE       3'h7
`define MODE_PROGRAMMABLE  1'h0
`define MODE_LEVEL         1'h1
`define POL_FALLING        1'h0
`define POL_RISING         1'h1

// ==========================================================================
// Capture control fields
`define CAP_REPEAT_BIT     0
`define CAP_SINGLE_BIT     1
`define CAP_READOUT_BIT    2

// ==========================================================================
// Reset values and widths
`define SHUTTER_RESET      12'h064
`define SHUTTER_WIDTH      12

// ==========================================================================
// Timing
`define CLOCK_HZ           50000000
`define TIME_BASE_US       20
`define TIME_BASE_CYCLES   ((`TIME_BASE_US * `CLOCK_HZ) / 1000000)
`define SETUP_DELAY_CYCLES 16
`define READOUT_CYCLES     7'h40

`endif

// *** verilog/exposure_start_trigger_control.v ***
/*
 * Exposure start controller: software or external-pin trigger, programmable
 * or level-controlled exposure with a shutter-set minimum, and readout start.
 * Assumes an APB master on clock_i and four asynchronous trigger input ports.
 */
// The APB slave port and the address map are this design's own decisions.
// Notes on behaviour
// - Software source forces programmable exposure; level mode is ignored for it.
// - Software source starts exposure when the soft fire bit is written 1.
// - Programmable exposure ends after shutter value times time base.
// - Soft fire bit clears itself once its exposure has begun.
// - Source select 7 picks the software trigger.
// - Mode select 0 picks programmable exposure.
// - Exposure end launches readout and transmission of the image.
// - Repeat capture cleared stops further triggered captures.
// - Software trigger starts exposure with no setup latency.
// - Single-capture request waits a setup delay before exposing.
// - New exposure may start while previous readout is running.
// - External source detects the configured edge as start event.
// - Programmable external mode starts exposure on the active edge.
// - Level mode exposes from active edge until the opposite edge.
// - Level mode pulse not above minimum is extended to the minimum.
// - Level mode pulse above minimum sets the exposure length.
// - Exposure equals shutter value 1..4095 times 20 us time base.
// - Polarity 0 selects falling edge, 1 selects rising edge.
// - Mode select 1 picks level exposure, external sources only.
// - Source select 0..3 picks one of four input ports, 0 default.
`timescale 1ns/1ps
`default_nettype none
`include "exposure_start_defs.vh"

module exposure_start_trigger_control (
  input  wire        clock_i,                // 50 MHz system clock
  input  wire        nrst_i,                 // Asynchronous reset, active low
  input  wire        psel_i,                 // APB select
  input  wire        penable_i,              // APB access phase
  input  wire        pwrite_i,               // APB write
  input  wire [11:0] paddr_i,                // APB byte address
  input  wire [31:0] pwdata_i,               // APB write data
  output wire        pready_o,               // APB ready, always high
  output reg  [31:0] prdata_o,               // APB read data
  output wire        pslverr_o,              // APB error on unmapped address
  input  wire [3:0]  external_start_input_i, // Physical trigger input ports
  output wire        start_ready_flag_o,     // High when idle and no single capture is pending
  output reg         exposing_o,             // High during exposure
  output reg         readout_start_o         // Pulse: begin readout of image
);

  // ========================================================================
  // State encodings
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_SETUP = 2'h1;
  localparam [1:0] ST_EXPO  = 2'h2;

  // ========================================================================
  // Registers
  reg                       trig_enable;
  reg                       trig_polarity;
  reg                       trig_mode;
  reg  [2:0]                trig_source;
  reg                       soft_fire;
  reg  [`SHUTTER_WIDTH-1:0] shutter;
  reg                       repeat_capture;
  reg                       single_capture;
  reg  [1:0]                state;
  reg  [9:0]                base_cnt;
  reg  [`SHUTTER_WIDTH-1:0] units;
  reg                       min_done;
  reg                       level_held;
  reg  [4:0]                setup_cnt;
  reg  [6:0]                readout_cnt;
  reg  [3:0]                pin_meta;
  reg  [3:0]                pin_sync;
  reg                       pin_last;

  // ========================================================================
  // Decoding
  function is_reg;
    input [11:0] addr;
    input [3:0]  offs;
    begin
      is_reg = (addr == {8'h00, offs});
    end
  endfunction

  wire        setup_phase = psel_i & ~penable_i;
  wire        wr_access   = psel_i & penable_i & pwrite_i;
  wire        mapped      = is_reg(paddr_i, `REG_TRIG_MODE) | is_reg(paddr_i, `REG_SOFT_FIRE) |
                            is_reg(paddr_i, `REG_SHUTTER) | is_reg(paddr_i, `REG_CAPTURE);
  wire        use_soft    = (trig_source == `SRC_SOFTWARE);
  wire        level_mode  = (trig_mode == `MODE_LEVEL) & ~use_soft;
  wire        sel_pin     = pin_sync[trig_source[1:0]];
  wire        rise        = sel_pin & ~pin_last;
  wire        fall        = ~sel_pin & pin_last;
  wire        active_lvl  = (trig_polarity == `POL_RISING) ? sel_pin : ~sel_pin;
  wire        active_edge = (trig_polarity == `POL_RISING) ? rise : fall;
  wire        ext_ok      = ~use_soft & trig_source[2] == 1'b0;
  wire        armed       = trig_enable & repeat_capture;
  wire        idle        = (state == ST_IDLE);
  wire        soft_go     = idle & armed & use_soft & soft_fire;
  wire        ext_go      = idle & armed & ext_ok & active_edge;
  wire        single_go   = idle & single_capture & ~armed;
  wire        base_tick   = (base_cnt == `TIME_BASE_CYCLES - 1);
  wire        exp_end;

  assign pready_o           = 1'b1;
  assign pslverr_o          = psel_i & penable_i & ~mapped;
  assign start_ready_flag_o = idle & ~single_capture;

  // Programmable ends on minimum; level waits for both minimum and release
  assign exp_end = (state == ST_EXPO) & (level_mode ? (min_done & ~level_held) : min_done);

  // ========================================================================
  // Input synchroniser, first stage read only by the second
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pin_last <= 1'b0;
    end else begin
      pin_meta <= external_start_input_i;
      pin_sync <= pin_meta;
      pin_last <= sel_pin;
    end
  end

  // ========================================================================
  // Register writes
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_enable    <= 1'b0;
      trig_polarity  <= `POL_RISING;
      trig_mode      <= `MODE_PROGRAMMABLE;
      trig_source    <= 3'h0;
      soft_fire      <= 1'b0;
      shutter        <= `SHUTTER_RESET;
      repeat_capture <= 1'b0;
    end else begin
      if (wr_access && is_reg(paddr_i, `REG_TRIG_MODE)) begin
        trig_enable   <= pwdata_i[`TM_ENABLE_BIT];
        trig_polarity <= pwdata_i[`TM_POLARITY_BIT];
        trig_mode     <= pwdata_i[`TM_MODE_BIT];
        trig_source   <= pwdata_i[`TM_SOURCE_MSB:`TM_SOURCE_LSB];
      end
      if (wr_access && is_reg(paddr_i, `REG_SHUTTER) && pwdata_i[11:0] != 12'h000) begin
        shutter <= pwdata_i[11:0];
      end
      if (wr_access && is_reg(paddr_i, `REG_CAPTURE)) begin
        repeat_capture <= pwdata_i[`CAP_REPEAT_BIT];
      end
      // A write of 1 wins over the self-clear in the same cycle
      if (wr_access && is_reg(paddr_i, `REG_SOFT_FIRE) && pwdata_i[0]) begin
        soft_fire <= 1'b1;
      end else if (soft_go) begin
        soft_fire <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Single capture request, cleared once readout is launched while repeat capture is not armed
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      single_capture <= 1'b0;
    end else if (wr_access && is_reg(paddr_i, `REG_CAPTURE) && pwdata_i[`CAP_SINGLE_BIT]) begin
      single_capture <= 1'b1;
    end else if (exp_end && !armed) begin
      single_capture <= 1'b0;
    end
  end

  // ========================================================================
  // Exposure sequencer
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state           <= ST_IDLE;
      base_cnt        <= 10'h000;
      units           <= 12'h000;
      min_done        <= 1'b0;
      level_held      <= 1'b0;
      setup_cnt       <= 5'h00;
      exposing_o      <= 1'b0;
      readout_start_o <= 1'b0;
    end else begin
      readout_start_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          base_cnt   <= 10'h000;
          units      <= 12'h000;
          min_done   <= 1'b0;
          level_held <= 1'b1;
          setup_cnt  <= 5'h00;
          if (soft_go || ext_go) begin
            state      <= ST_EXPO;
            exposing_o <= 1'b1;
          end else if (single_go) begin
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          setup_cnt <= setup_cnt + 5'h01;
          if (setup_cnt == `SETUP_DELAY_CYCLES - 1) begin
            state      <= ST_EXPO;
            exposing_o <= 1'b1;
          end
        end
        ST_EXPO: begin
          // Level is re-read every cycle so a release before the minimum is kept
          if (!active_lvl) begin
            level_held <= 1'b0;
          end
          if (base_tick) begin
            base_cnt <= 10'h000;
            if (!min_done) begin
              units <= units + 12'h001;
              if (units + 12'h001 == shutter) begin
                min_done <= 1'b1;
              end
            end
          end else begin
            base_cnt <= base_cnt + 10'h001;
          end
          if (exp_end) begin
            state           <= ST_IDLE;
            exposing_o      <= 1'b0;
            readout_start_o <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Readout busy counter; runs alongside the next exposure
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      readout_cnt <= 7'h00;
    end else if (readout_start_o) begin
      readout_cnt <= `READOUT_CYCLES;
    end else if (readout_cnt != 7'h00) begin
      readout_cnt <= readout_cnt - 7'h01;
    end
  end

  // ========================================================================
  // Read data, registered in the setup phase so it is stable at access
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_o <= 32'h00000000;
    end else if (setup_phase && !pwrite_i) begin
      prdata_o <= 32'h00000000;
      if (is_reg(paddr_i, `REG_TRIG_MODE)) begin
        prdata_o[`TM_ENABLE_BIT]                  <= trig_enable;
        prdata_o[`TM_POLARITY_BIT]                <= trig_polarity;
        prdata_o[`TM_MODE_BIT]                    <= trig_mode;
        prdata_o[`TM_SOURCE_MSB:`TM_SOURCE_LSB]   <= trig_source;
      end
      if (is_reg(paddr_i, `REG_SOFT_FIRE)) begin
        prdata_o[0] <= soft_fire;
      end
      if (is_reg(paddr_i, `REG_SHUTTER)) begin
        prdata_o[11:0] <= shutter;
      end
      if (is_reg(paddr_i, `REG_CAPTURE)) begin
        prdata_o[`CAP_REPEAT_BIT]  <= repeat_capture;
        prdata_o[`CAP_SINGLE_BIT]  <= single_capture;
        prdata_o[`CAP_READOUT_BIT] <= (readout_cnt != 7'h00);
        prdata_o[3]                <= exposing_o;
      end
    end
  end

endmodule

`default_nettype wire
